// ---- logic/tcm_consts.vh ----
// Register offsets, field positions and reset values of the timer block.
`ifndef TCM_CONSTS_VH
`define TCM_CONSTS_VH
`define TCM_ADDR_GTC 8'h2C
`define TCM_ADDR_CNT 8'h2F
`define TCM_ADDR_CTL 8'h30
`define TCM_ADDR_IFR 8'h38
`define TCM_ADDR_IMSK 8'h39
`define TCM_ADDR_CMPA 8'h2E
`define TCM_ADDR_TOP 8'h2D
`define TCM_ADDR_GIE 8'h3F
`define TCM_ADDR_ACK 8'h3E
`define TCM_CTL_CLR 7
`define TCM_CTL_PWM 6
`define TCM_CTL_COM_HI 5
`define TCM_CTL_COM_LO 4
`define TCM_GTC_FORCE 2
`define TCM_GTC_PSR 1
`define TCM_FLG_CMPA 6
`define TCM_FLG_OVF 2
`define TCM_GIE_BIT 7
`define TCM_RST_BYTE 8'h00
`define TCM_RST_TOP 8'hFF
`define TCM_PCK_DIV 2'd2
`endif

// ---- logic/tcm_prescaler.v ----
// Prescaler producing one-cycle count ticks from the clock select code.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_consts.vh"
module tcm_prescaler (
  // Clock and reset
  input wire clock_i,
  input wire srst_i,
  // Control
  input wire [3:0] clock_select_i,
  input wire prescaler_reset_i,
  // Tick
  output reg tick_o
);
  // The fast peripheral clock is modelled as a fixed enable stream at half the system rate, divided down further.
  reg [9:0] div_r;
  reg [1:0] pck_r;
  reg pck_tick;
  reg [9:0] mask;
  always @* begin
    pck_tick = (pck_r == 2'd0);
    mask = 10'h000;
    if (clock_select_i >= 4'h5) begin
      mask = (10'h001 << (clock_select_i - 4'h5)) - 10'h001;
    end else if (clock_select_i >= 4'h2) begin
      mask = (10'h001 << (clock_select_i - 4'h1)) - 10'h001;
    end
  end
  always @(posedge clock_i) begin
    if (srst_i || prescaler_reset_i) begin
      div_r <= 10'h000;
      pck_r <= 2'd0;
      tick_o <= 1'b0;
    end else begin
      pck_r <= (pck_r == `TCM_PCK_DIV - 2'd1) ? 2'd0 : pck_r + 2'd1;
      if (clock_select_i == 4'h0) begin
        tick_o <= 1'b0;
      end else if (clock_select_i <= 4'h4) begin
        if (pck_tick) begin
          div_r <= div_r + 10'h001;
        end
        tick_o <= pck_tick && ((div_r & mask) == 10'h000);
      end else begin
        div_r <= div_r + 10'h001;
        tick_o <= ((div_r & mask) == 10'h000);
      end
    end
  end
endmodule
`default_nettype wire

// ---- logic/tcm_timer.v ----
// Timer/counter with compare A, top compare, PWM and flags behind a register port.
//
// Summary of operation
// - Clear-on-match returns counter to zero after match only at clock select 5, where a tick comes every cycle.
// - PWM mode restarts counter after top match.
// - Mode bits pick pin toggle, clear, set.
// - Clock select stops or divides clock.
// - Force applies pin action, sets no flag.
// - Force uses mode written same cycle; force and mode are at separate addresses, so force uses the stored mode.
// - Force reads zero, ignored in PWM.
// - Prescaler reset leaves counter, self-clears.
// - Counter write lands one cycle later.
// - Compare A matches only when counting.
// - Top matches only when counting.
// - Clear-on-match also clears at top.
// - Compare A match sets flag after delay.
// - Compare A interrupt needs both enables.
// - Overflow sets flag, interrupts when enabled.
// - Compare A flag cleared by ack or one.
// - PWM pin low/high at match and zero.
// - PWM compare A buffered until top.
// - PWM overflow flag set at top restart.
// - Overflow flag cleared by ack or one.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_consts.vh"
module tcm_timer (
  // Clock and reset
  input wire clock_i,
  input wire srst_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Pin and interrupt requests
  output reg compare_a_pin_o,
  output reg compare_a_pin_oe_o,
  output reg irq_compare_a_o,
  output reg irq_overflow_o
);
  reg [7:0] ctl_r;
  reg [7:0] cnt_r;
  reg [7:0] cmpa_r;
  reg [7:0] cmpa_hold_r;
  reg [7:0] top_r;
  reg cmpa_ie_r;
  reg ovf_ie_r;
  reg gie_r;
  reg cmpa_flag_r;
  reg ovf_flag_r;
  reg cnt_wr_r;
  reg [7:0] cnt_wdata_r;
  reg cmpa_ev_r;
  reg ovf_ev_r;
  reg clr_cmpa_r;
  reg clr_ovf_r;
  reg pin_r;
  wire tick;
  wire psr_pulse;
  wire wr_gtc;
  wire wr_ctl;
  wire wr_ifr;
  wire wr_ack;
  reg [7:0] cnt_nxt;
  reg pin_nxt;
  reg [7:0] rd_nxt;
  reg [1:0] mode;
  reg pwm;
  reg match_a;
  reg match_top;
  reg wrap;

  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  function [7:0] regsel;
    input [7:0] a;
    input [7:0] b;
    begin
      regsel = wr_i && (addr_i == a) ? 8'hFF : 8'h00;
      regsel = regsel & b;
    end
  endfunction

  assign wr_gtc = wr_i && (addr_i == `TCM_ADDR_GTC);
  assign wr_ctl = wr_i && (addr_i == `TCM_ADDR_CTL);
  assign wr_ifr = wr_i && (addr_i == `TCM_ADDR_IFR);
  assign wr_ack = wr_i && (addr_i == `TCM_ADDR_ACK);
  assign psr_pulse = wr_gtc && wdata_i[`TCM_GTC_PSR];

  tcm_prescaler u_pre (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .clock_select_i(ctl_r[3:0]),
    .prescaler_reset_i(psr_pulse),
    .tick_o(tick)
  );

  // Counting logic; a pending software write suppresses matches for that cycle.
  always @* begin
    pwm = ctl_r[`TCM_CTL_PWM];
    mode = wr_ctl ? wdata_i[`TCM_CTL_COM_HI:`TCM_CTL_COM_LO] : ctl_r[`TCM_CTL_COM_HI:`TCM_CTL_COM_LO];
    match_a = tick && !cnt_wr_r && hit(cnt_r + 8'h01, cmpa_r);
    match_top = tick && !cnt_wr_r && hit(cnt_r, top_r) && (pwm || ctl_r[`TCM_CTL_CLR]);
    wrap = 1'b0;
    cnt_nxt = cnt_r;
    if (cnt_wr_r) begin
      cnt_nxt = cnt_wdata_r;
    end else if (tick) begin
      if (match_top) begin
        cnt_nxt = 8'h00;
        wrap = pwm;
      end else if (ctl_r[`TCM_CTL_CLR] && !pwm && hit(cnt_r, cmpa_r) && cmpa_ev_r) begin
        cnt_nxt = 8'h00;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
        wrap = (cnt_r == 8'hFF);
      end
    end
    pin_nxt = pin_r;
    if (pwm) begin
      if (mode[1] && match_a) begin
        pin_nxt = ~mode[0];
      end else if (mode[1] && tick && cnt_nxt == 8'h00 && !cnt_wr_r) begin
        pin_nxt = mode[0];
      end
    end else if (match_a || (wr_gtc && wdata_i[`TCM_GTC_FORCE])) begin
      case (mode)
        2'b01: pin_nxt = ~pin_r;
        2'b10: pin_nxt = 1'b0;
        2'b11: pin_nxt = 1'b1;
        default: pin_nxt = pin_r;
      endcase
    end
  end

  // Read mux; reserved bits and self-clearing bits return zero.
  always @* begin
    case (addr_i)
      `TCM_ADDR_GTC: rd_nxt = 8'h00;
      `TCM_ADDR_CNT: rd_nxt = cnt_r;
      `TCM_ADDR_CTL: rd_nxt = ctl_r;
      `TCM_ADDR_IFR: rd_nxt = {1'b0, cmpa_flag_r, 3'b000, ovf_flag_r, 2'b00};
      `TCM_ADDR_IMSK: rd_nxt = {1'b0, cmpa_ie_r, 3'b000, ovf_ie_r, 2'b00};
      `TCM_ADDR_CMPA: rd_nxt = cmpa_hold_r;
      `TCM_ADDR_TOP: rd_nxt = top_r;
      `TCM_ADDR_GIE: rd_nxt = {gie_r, 7'h00};
      default: rd_nxt = 8'h00;
    endcase
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      ctl_r <= `TCM_RST_BYTE;
      cnt_r <= `TCM_RST_BYTE;
      cmpa_r <= `TCM_RST_BYTE;
      cmpa_hold_r <= `TCM_RST_BYTE;
      top_r <= `TCM_RST_TOP;
      cmpa_ie_r <= 1'b0;
      ovf_ie_r <= 1'b0;
      gie_r <= 1'b0;
      cmpa_flag_r <= 1'b0;
      ovf_flag_r <= 1'b0;
      cnt_wr_r <= 1'b0;
      cnt_wdata_r <= `TCM_RST_BYTE;
      cmpa_ev_r <= 1'b0;
      ovf_ev_r <= 1'b0;
      clr_cmpa_r <= 1'b0;
      clr_ovf_r <= 1'b0;
      pin_r <= 1'b0;
      rdata_o <= 8'h00;
      compare_a_pin_o <= 1'b0;
      compare_a_pin_oe_o <= 1'b0;
      irq_compare_a_o <= 1'b0;
      irq_overflow_o <= 1'b0;
    end else begin
      rdata_o <= rd_i ? rd_nxt : 8'h00;
      if (wr_ctl) begin
        ctl_r <= wdata_i;
      end
      if (wr_i && addr_i == `TCM_ADDR_IMSK) begin
        cmpa_ie_r <= wdata_i[`TCM_FLG_CMPA];
        ovf_ie_r <= wdata_i[`TCM_FLG_OVF];
      end
      if (wr_i && addr_i == `TCM_ADDR_GIE) begin
        gie_r <= wdata_i[`TCM_GIE_BIT];
      end
      if (wr_i && addr_i == `TCM_ADDR_TOP) begin
        top_r <= wdata_i;
      end
      cnt_wr_r <= wr_i && addr_i == `TCM_ADDR_CNT;
      if (wr_i && addr_i == `TCM_ADDR_CNT) begin
        cnt_wdata_r <= wdata_i;
      end
      cnt_r <= cnt_nxt;
      // Outside PWM the active compare value follows writes; in PWM it waits for top.
      if (wr_i && addr_i == `TCM_ADDR_CMPA) begin
        cmpa_hold_r <= wdata_i;
        if (!ctl_r[`TCM_CTL_PWM]) begin
          cmpa_r <= wdata_i;
        end
      end else if (ctl_r[`TCM_CTL_PWM] && match_top) begin
        cmpa_r <= cmpa_hold_r;
      end
      // One sync stage between the event and the visible flag.
      cmpa_ev_r <= match_a;
      ovf_ev_r <= wrap;
      clr_cmpa_r <= (wr_ifr && wdata_i[`TCM_FLG_CMPA]) || (wr_ack && wdata_i[`TCM_FLG_CMPA]);
      clr_ovf_r <= (wr_ifr && wdata_i[`TCM_FLG_OVF]) || (wr_ack && wdata_i[`TCM_FLG_OVF]);
      // A new event wins over a clear landing in the same cycle.
      if (cmpa_ev_r) begin
        cmpa_flag_r <= 1'b1;
      end else if (clr_cmpa_r) begin
        cmpa_flag_r <= 1'b0;
      end
      if (ovf_ev_r) begin
        ovf_flag_r <= 1'b1;
      end else if (clr_ovf_r) begin
        ovf_flag_r <= 1'b0;
      end
      pin_r <= pin_nxt;
      compare_a_pin_o <= pin_nxt;
      compare_a_pin_oe_o <= (wr_ctl ? wdata_i[`TCM_CTL_COM_HI] | (wdata_i[`TCM_CTL_COM_LO] & ~wdata_i[`TCM_CTL_PWM])
        : (mode[1] | (mode[0] & ~pwm)));
      irq_compare_a_o <= gie_r && cmpa_ie_r && (cmpa_flag_r || cmpa_ev_r) && !clr_cmpa_r;
      irq_overflow_o <= gie_r && ovf_ie_r && (ovf_flag_r || ovf_ev_r) && !clr_ovf_r;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tcm_timer_properties.sv ----
// Port-level checks of the timer block.
`timescale 1ns/100ps
`default_nettype none
module tcm_timer_chk (
  // Clock, reset and register port
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Pin and interrupts
  input wire logic compare_a_pin_o,
  input wire logic compare_a_pin_oe_o,
  input wire logic irq_compare_a_o,
  input wire logic irq_overflow_o
);
  logic [7:0] ctl_r;
  logic gie_r;
  wire frc_w = wr_i && addr_i == 8'h2C && wdata_i[2];
  // Shadow copies of control writes, so pin checks know the mode in force.
  always @(posedge clock_i) begin
    if (srst_i) begin
      ctl_r <= 8'h00;
      gie_r <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == 8'h30) ctl_r <= wdata_i;
      if (addr_i == 8'h3F) gie_r <= wdata_i[7];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  a_gtc_zero: assert property ($past(rd_i) && $past(addr_i) == 8'h2C |-> rdata_o[2:1] == 2'h0)
    else $error("self-clearing bits read back");
  a_rsvd_zero: assert property ($past(rd_i) && $past(addr_i[7:1]) == 7'h1C |-> (rdata_o & 8'hBB) == 8'h00)
    else $error("reserved bits not zero");
  a_force_high: assert property (frc_w && ctl_r[6:4] == 3'b011 |-> ##[1:2] compare_a_pin_o)
    else $error("forced set missing");
  a_force_pwm: assert property (frc_w && ctl_r[6] && ctl_r[3:0] == 4'h0 |=> $stable(compare_a_pin_o) [*3])
    else $error("force acted in pwm");
  a_oe_off: assert property (wr_i && addr_i == 8'h30 && (wdata_i[5:4] == 2'b00 || wdata_i[6:5] == 2'b10)
    |-> ##2 !compare_a_pin_oe_o) else $error("pin still connected");
  a_gie_off: assert property (!gie_r && !$past(gie_r) |-> !irq_compare_a_o && !irq_overflow_o)
    else $error("irq without global enable");
  a_cnt_load: assert property (wr_i && addr_i == 8'h2F && ctl_r[3:0] == 4'h0 ##2 rd_i && addr_i == 8'h2F
    |=> rdata_o == $past(wdata_i, 3)) else $error("counter write lost");
endmodule
bind tcm_timer tcm_timer_chk u_chk (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .compare_a_pin_o(compare_a_pin_o),
  .compare_a_pin_oe_o(compare_a_pin_oe_o), .irq_compare_a_o(irq_compare_a_o), .irq_overflow_o(irq_overflow_o));
`default_nettype wire

// ---- tb/tcm_timer_tb.sv ----
// Directed register-level test of the timer block.
`timescale 1ns/100ps
`default_nettype none
module tcm_timer_tb;
  logic clock_i, srst_i, wr_i, rd_i, p;
  logic [7:0] addr_i, wdata_i, q;
  wire [7:0] rdata_o;
  wire pin, oe, irq_a, irq_o;
  int n_mismatch = 0, cmp_count = 0, t = 0;
  logic [7:0] ra [6] = '{8'h2C, 8'h2F, 8'h30, 8'h38, 8'h39, 8'h2D};
  logic [7:0] md [3] = '{8'h30, 8'h20, 8'h10};
  tcm_timer u_dut (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .compare_a_pin_o(pin), .compare_a_pin_oe_o(oe), .irq_compare_a_o(irq_a),
    .irq_overflow_o(irq_o));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task tend;
    t++;
    $display("test %0d done", t);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task rq(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    rq(a);
    chk(q, e);
  endtask
  initial begin
    repeat (5000) @(posedge clock_i);
    $display("Error %0t: timeout", $time);
    n_mismatch++;
    final_report;
  end
  initial begin
    srst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    cyc(5);
    srst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rc(ra[i], i == 5 ? 8'hFF : 8'h00);
    wr(8'h10, 8'hA5);
    rc(8'h10, 8'h00);
    wr(8'h39, 8'hFF);
    rc(8'h39, 8'h44);
    wr(8'h2C, 8'h06);
    rc(8'h2C, 8'h00);
    tend;
    wr(8'h2F, 8'h10);
    rc(8'h2F, 8'h10);
    wr(8'h2C, 8'h02);
    rc(8'h2F, 8'h10);
    tend;
    for (int i = 0; i < 3; i++) begin
      wr(8'h30, md[i]);
      wr(8'h2C, 8'h04);
      cyc(2);
      chk({6'h0, oe, pin}, i == 1 ? 8'h02 : 8'h03);
    end
    rc(8'h38, 8'h00);
    tend;
    wr(8'h30, 8'h00);
    wr(8'h2E, 8'h05);
    wr(8'h2F, 8'h00);
    wr(8'h3F, 8'h80);
    wr(8'h30, 8'h85);
    cyc(40);
    // Keep clear-on-match on while stopping, since one tick already in flight still lands.
    wr(8'h30, 8'h80);
    cyc(4);
    rq(8'h2F);
    chk({7'h0, q < 8'h06}, 8'h01);
    chk({7'h0, irq_a}, 8'h01);
    rc(8'h38, 8'h40);
    wr(8'h3E, 8'h40);
    cyc(4);
    chk({7'h0, irq_a}, 8'h00);
    rc(8'h38, 8'h00);
    tend;
    wr(8'h2F, 8'hFD);
    wr(8'h2E, 8'hFD);
    wr(8'h30, 8'h05);
    cyc(10);
    wr(8'h30, 8'h00);
    cyc(4);
    rc(8'h38, 8'h04);
    chk({7'h0, irq_o}, 8'h01);
    wr(8'h38, 8'h04);
    cyc(2);
    rc(8'h38, 8'h00);
    tend;
    wr(8'h2D, 8'h03);
    wr(8'h2E, 8'h01);
    wr(8'h2F, 8'h00);
    wr(8'h30, 8'h65);
    cyc(30);
    wr(8'h30, 8'h60);
    cyc(6);
    rq(8'h2F);
    chk({7'h0, q < 8'h04}, 8'h01);
    rc(8'h38, 8'h44);
    p = pin;
    wr(8'h2C, 8'h04);
    cyc(3);
    chk({6'h0, oe, pin}, {6'h0, 1'b1, p});
    wr(8'h2E, 8'h02);
    rc(8'h2E, 8'h02);
    tend;
    final_report;
  end
endmodule
`default_nettype wire
